// [rtl/dop_pkg.sv]
// Purpose: Shared constants and types for the digital output port
// Assumes: 10 MHz system clock
// Notes: Register offsets are byte addresses on a 32-bit word port
package dop_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] A_PATTERN = 8'h00;
  localparam logic [7:0] A_CTRL = 8'h04;
  localparam logic [7:0] A_DELAY = 8'h08;
  localparam logic [7:0] A_PASSFAIL = 8'h0c;
  localparam logic [7:0] A_CLEAR = 8'h10;
  localparam logic [7:0] A_STATUS = 8'h14;
  localparam logic [7:0] A_TEXT = 8'h18;

  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int unsigned LINES = 4;
  localparam logic [3:0] PATTERN_RST = 4'hf;
  localparam logic [31:0] PATTERN_LIMIT = 32'h0000000f;
  localparam int unsigned DELAY_W = 20;
  localparam logic [19:0] DELAY_RST = 20'h00001;
  localparam logic [31:0] DELAY_LIMIT = 32'h000927c0;
  localparam int unsigned C_AUTO = 0;
  localparam int unsigned C_MODE = 1;
  localparam int unsigned C_POL = 2;
  localparam int unsigned C_FMT = 4;
  localparam int unsigned S_PF = 4;
  localparam int unsigned S_BUSY = 5;
  localparam int unsigned S_ERR = 6;
  localparam int unsigned S_RUN = 7;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_NS = 100;
  localparam int unsigned UNIT_NS = 100000;
  localparam int unsigned TICK_CYC = UNIT_NS / CLK_NS;
  localparam int unsigned TICK_W = 10;
  localparam int unsigned EOT_NS = 10000;
  localparam int unsigned EOT_CYC = (EOT_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned EOT_W = 8;

  // ----------------------------------------
  // Characters and enumerations
  // ----------------------------------------
  localparam logic [7:0] ASC_ZERO = 8'h30;
  localparam logic [7:0] ASC_ONE = 8'h31;
  localparam logic [7:0] ASC_HEX_OFS = 8'h37;
  localparam logic [3:0] DEC_TEN = 4'ha;

  typedef enum logic [1:0] {
    FMT_ASCII = 2'h0,
    FMT_HEX = 2'h1,
    FMT_OCT = 2'h2,
    FMT_BIN = 2'h3
  } dop_fmt_t;

  typedef enum logic {
    L4_EOT = 1'b0,
    L4_BUSY = 1'b1
  } dop_l4_mode_t;

  typedef enum logic [1:0] {
    T_IDLE = 2'h0,
    T_RUN = 2'h1
  } dop_tmr_st_t;

endpackage

// [rtl/dop_if.sv]
// Purpose: Carrier between the port core, its pulse timer and line 4 driver
// Assumes: One clock domain
// Notes: Three modports, one per module
`timescale 1ns/1ps
interface dop_if;
  logic tmr_start;
  logic [dop_pkg::DELAY_W-1:0] tmr_len;
  logic tmr_abort;
  logic tmr_done;
  logic tmr_run;
  dop_pkg::dop_l4_mode_t l4_mode;
  logic l4_pol;
  logic l4_busy;
  logic l4_test_done;
  logic l4_base;
  logic l4_level;

  modport core (
    output tmr_start, tmr_len, tmr_abort, l4_mode, l4_pol, l4_busy, l4_test_done, l4_base,
    input tmr_done, tmr_run, l4_level
  );
  modport tmr (
    input tmr_start, tmr_len, tmr_abort,
    output tmr_done, tmr_run
  );
  modport l4 (
    input l4_mode, l4_pol, l4_busy, l4_test_done, l4_base,
    output l4_level
  );
endinterface

// [rtl/dop_pulse_timer.sv]
// Purpose: Pass/fail pulse width timer in 100 us units
// Assumes: Start and abort are single-cycle pulses
// Notes: Length zero gives done one cycle after start
`timescale 1ns/1ps
module dop_pulse_timer (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  dop_if.tmr t
);

  typedef struct packed {
    dop_pkg::dop_tmr_st_t st;
    logic [dop_pkg::TICK_W-1:0] tick;
    logic [dop_pkg::DELAY_W-1:0] units;
    logic done;
  } dop_tmr_state_t;

  dop_tmr_state_t st_reg;
  dop_tmr_state_t st_next;

  // ----------------------------------------
  // Countdown
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (t.tmr_abort) begin
      st_next.st = dop_pkg::T_IDLE;
    end else if (t.tmr_start) begin
      st_next.tick = '0;
      st_next.units = t.tmr_len;
      if (t.tmr_len == '0) begin
        st_next.done = 1'b1;
        st_next.st = dop_pkg::T_IDLE;
      end else begin
        st_next.st = dop_pkg::T_RUN;
      end
    end else begin
      case (st_reg.st)
        dop_pkg::T_RUN: begin
          if (st_reg.tick == dop_pkg::TICK_W'(dop_pkg::TICK_CYC - 1)) begin
            st_next.tick = '0;
            if (st_reg.units == dop_pkg::DELAY_W'(1)) begin
              st_next.done = 1'b1;
              st_next.st = dop_pkg::T_IDLE;
            end else begin
              st_next.units = st_reg.units - dop_pkg::DELAY_W'(1);
            end
          end else begin
            st_next.tick = st_reg.tick + dop_pkg::TICK_W'(1);
          end
        end
        default: begin
          st_next.st = dop_pkg::T_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '{st: dop_pkg::T_IDLE, tick: '0, units: '0, done: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign t.tmr_done = st_reg.done;
  assign t.tmr_run = (st_reg.st == dop_pkg::T_RUN);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [31:0] chk_cnt;
  logic [31:0] chk_len;
  logic chk_armed;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chk_cnt <= 32'h0;
      chk_len <= 32'h0;
      chk_armed <= 1'b0;
    end else if (t.tmr_abort) begin
      chk_armed <= 1'b0;
    end else if (t.tmr_start) begin
      chk_cnt <= 32'h1;
      chk_len <= 32'(t.tmr_len);
      chk_armed <= 1'b1;
    end else begin
      chk_cnt <= chk_cnt + 32'h1;
    end
  end

  // R06: width in cycles
  a_timer_width: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R06
    (st_reg.done && chk_armed) |-> (chk_cnt == chk_len * dop_pkg::TICK_CYC + 32'h1))
    else $error("Pulse timer done at wrong cycle");

endmodule

// [rtl/dop_line4.sv]
// Purpose: Line 4 driver for end-of-test strobe or busy level
// Assumes: Test done is a one-cycle pulse from the measurement engine
// Notes: End-of-test strobe inverts the pattern bit for a fixed time
`timescale 1ns/1ps
module dop_line4 (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  dop_if.l4 l
);

  typedef struct packed {
    logic [dop_pkg::EOT_W-1:0] eot_cnt;
    logic level;
  } dop_l4_state_t;

  dop_l4_state_t st_reg;
  dop_l4_state_t st_next;

  // ----------------------------------------
  // Line 4 level
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    if (l.l4_mode == dop_pkg::L4_BUSY) begin
      st_next.eot_cnt = '0;
      // R08: busy active level
      st_next.level = l.l4_busy ? l.l4_pol : ~l.l4_pol;
    end else begin
      // R11: strobe restarts on each test done, so close tests share one strobe
      if (l.l4_test_done) begin
        st_next.eot_cnt = dop_pkg::EOT_W'(dop_pkg::EOT_CYC);
      end else if (st_reg.eot_cnt != '0) begin
        st_next.eot_cnt = st_reg.eot_cnt - dop_pkg::EOT_W'(1);
      end
      st_next.level = (st_next.eot_cnt != '0) ? ~l.l4_base : l.l4_base;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '{eot_cnt: '0, level: dop_pkg::PATTERN_RST[3]};
    end else begin
      st_reg <= st_next;
    end
  end

  assign l.l4_level = st_reg.level;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_busy_level: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R08
    (l.l4_mode == dop_pkg::L4_BUSY) |=> (l.l4_level == ($past(l.l4_busy) ~^ $past(l.l4_pol))))
    else $error("Busy level wrong on line 4");

  a_busy_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R11
    (l.l4_mode == dop_pkg::L4_BUSY && l.l4_busy) [*3] |=> (l.l4_level == $past(l.l4_pol)))
    else $error("Line 4 left active level during busy");

  a_eot_strobe: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R07
    (l.l4_mode == dop_pkg::L4_EOT && l.l4_test_done) |=> (l.l4_level == ~$past(l.l4_base)))
    else $error("No end-of-test strobe on line 4");

endmodule

// [rtl/dop_port.sv]
// Purpose: Four-line digital output port with pass/fail pulse and line 4 modes
// Assumes: Busy and test done come from logic on the same clock
// Notes: Read data stand for one cycle after the read strobe, else zero
`timescale 1ns/1ps

// How it works
// R01: Four-bit base pattern drives the lines; all ones after reset.
// R02: Pattern writes above fifteen are refused and flag an error.
// R03: A clear write returns the lines from pass/fail to the base pattern.
// R04: Clear acts at once, aborting any running pulse timer.
// R05: Auto-clear is off after reset; when on, pass/fail ends by itself.
// R06: Pass/fail holds for the set width, 0 to 60 s, default 100 us.
// R07: Line 4 runs in end-of-test or busy mode, end-of-test after reset.
// R08: Busy mode drives line 4 to the chosen level, low after reset.
// R09: All settings read back: pattern, auto-clear, delay, mode, level.
// R10: Pattern also reads back as text in the chosen number format.
// R11: Busy holds line 4 active during measurement; end-of-test strobe restarts on each test done.
module dop_port (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [dop_pkg::ADDR_W-1:0] addr_i,
  input wire logic [dop_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [dop_pkg::DATA_W-1:0] rdata_o,
  input wire logic meas_busy_i,
  input wire logic test_done_i,
  output logic [dop_pkg::LINES-1:0] lines_o
);

  typedef struct packed {
    logic [3:0] pattern;
    logic [3:0] pf_pattern;
    logic pf_active;
    logic auto_clr;
    dop_pkg::dop_l4_mode_t l4_mode;
    logic l4_pol;
    dop_pkg::dop_fmt_t fmt;
    logic [dop_pkg::DELAY_W-1:0] delay;
    logic err;
    logic [2:0] lines;
    logic [dop_pkg::DATA_W-1:0] rdata;
    logic tmr_start;
    logic tmr_abort;
  } dop_core_state_t;

  dop_core_state_t st_reg;
  dop_core_state_t st_next;
  dop_if bus_if ();

  // ----------------------------------------
  // Pattern as text
  // ----------------------------------------
  function automatic logic [31:0] dop_text(input logic [3:0] v, input dop_pkg::dop_fmt_t f);
    logic [31:0] txt;
    txt = 32'h0;
    case (f)
      dop_pkg::FMT_HEX: begin
        txt[7:0] = (v < dop_pkg::DEC_TEN) ? dop_pkg::ASC_ZERO + 8'(v)
                                         : dop_pkg::ASC_HEX_OFS + 8'(v);
      end
      dop_pkg::FMT_OCT: begin
        txt[7:0] = dop_pkg::ASC_ZERO + 8'(v[2:0]);
        if (v[3]) begin
          txt[15:8] = dop_pkg::ASC_ONE;
        end
      end
      dop_pkg::FMT_BIN: begin
        for (int i = 0; i < 4; i++) begin
          txt[8*i +: 8] = dop_pkg::ASC_ZERO + 8'(v[i]);
        end
      end
      default: begin
        if (v < dop_pkg::DEC_TEN) begin
          txt[7:0] = dop_pkg::ASC_ZERO + 8'(v);
        end else begin
          txt[7:0] = dop_pkg::ASC_ZERO + 8'(v - dop_pkg::DEC_TEN);
          txt[15:8] = dop_pkg::ASC_ONE;
        end
      end
    endcase
    return txt;
  endfunction

  // ----------------------------------------
  // Register port and pass/fail control
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.tmr_start = 1'b0;
    st_next.tmr_abort = 1'b0;
    st_next.rdata = '0;
    // R05: auto-clear on timer expiry
    if (bus_if.tmr_done && st_reg.auto_clr) begin
      st_next.pf_active = 1'b0;
    end
    if (wr_i) begin
      case (addr_i)
        dop_pkg::A_PATTERN: begin
          // R02: range check
          if (wdata_i <= dop_pkg::PATTERN_LIMIT) begin
            st_next.pattern = wdata_i[3:0];
          end else begin
            st_next.err = 1'b1;
          end
        end
        dop_pkg::A_CTRL: begin
          st_next.auto_clr = wdata_i[dop_pkg::C_AUTO];
          // R07: line 4 mode select
          st_next.l4_mode = dop_pkg::dop_l4_mode_t'(wdata_i[dop_pkg::C_MODE]);
          st_next.l4_pol = wdata_i[dop_pkg::C_POL];
          st_next.fmt = dop_pkg::dop_fmt_t'(wdata_i[dop_pkg::C_FMT +: 2]);
        end
        dop_pkg::A_DELAY: begin
          // R06: width range
          if (wdata_i <= dop_pkg::DELAY_LIMIT) begin
            st_next.delay = wdata_i[dop_pkg::DELAY_W-1:0];
          end else begin
            st_next.err = 1'b1;
          end
        end
        dop_pkg::A_PASSFAIL: begin
          if (wdata_i <= dop_pkg::PATTERN_LIMIT) begin
            st_next.pf_pattern = wdata_i[3:0];
            st_next.pf_active = 1'b1;
            // R06: start pulse timer
            st_next.tmr_start = st_reg.auto_clr;
            st_next.tmr_abort = ~st_reg.auto_clr;
          end else begin
            st_next.err = 1'b1;
          end
        end
        dop_pkg::A_CLEAR: begin
          // R03: back to base pattern
          st_next.pf_active = 1'b0;
          // R04: immediate clear
          st_next.tmr_abort = 1'b1;
        end
        dop_pkg::A_STATUS: begin
          if (wdata_i[dop_pkg::S_ERR]) begin
            st_next.err = 1'b0;
          end
        end
        default: begin
          st_next.err = st_reg.err;
        end
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        // R09: settings read back
        dop_pkg::A_PATTERN: st_next.rdata[3:0] = st_reg.pattern;
        dop_pkg::A_CTRL: begin
          st_next.rdata[dop_pkg::C_AUTO] = st_reg.auto_clr;
          st_next.rdata[dop_pkg::C_MODE] = st_reg.l4_mode;
          st_next.rdata[dop_pkg::C_POL] = st_reg.l4_pol;
          st_next.rdata[dop_pkg::C_FMT +: 2] = st_reg.fmt;
        end
        dop_pkg::A_DELAY: st_next.rdata[dop_pkg::DELAY_W-1:0] = st_reg.delay;
        dop_pkg::A_PASSFAIL: st_next.rdata[3:0] = st_reg.pf_pattern;
        dop_pkg::A_STATUS: begin
          st_next.rdata[3:0] = lines_o;
          st_next.rdata[dop_pkg::S_PF] = st_reg.pf_active;
          st_next.rdata[dop_pkg::S_BUSY] = meas_busy_i;
          st_next.rdata[dop_pkg::S_ERR] = st_reg.err;
          st_next.rdata[dop_pkg::S_RUN] = bus_if.tmr_run;
        end
        // R10: text readback
        dop_pkg::A_TEXT: st_next.rdata = dop_text(st_reg.pattern, st_reg.fmt);
        default: st_next.rdata = '0;
      endcase
    end
    // R01: lines follow base or pass/fail
    st_next.lines = st_next.pf_active ? st_next.pf_pattern[2:0] : st_next.pattern[2:0];
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '{pattern: dop_pkg::PATTERN_RST, pf_pattern: dop_pkg::PATTERN_RST,
                  pf_active: 1'b0, auto_clr: 1'b0, l4_mode: dop_pkg::L4_EOT,
                  l4_pol: 1'b0, fmt: dop_pkg::FMT_ASCII, delay: dop_pkg::DELAY_RST,
                  err: 1'b0, lines: dop_pkg::PATTERN_RST[2:0], rdata: '0,
                  tmr_start: 1'b0, tmr_abort: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  assign bus_if.tmr_start = st_reg.tmr_start;
  assign bus_if.tmr_len = st_reg.delay;
  assign bus_if.tmr_abort = st_reg.tmr_abort;
  assign bus_if.l4_mode = st_reg.l4_mode;
  assign bus_if.l4_pol = st_reg.l4_pol;
  assign bus_if.l4_busy = meas_busy_i;
  assign bus_if.l4_test_done = test_done_i;
  assign bus_if.l4_base = st_reg.pf_active ? st_reg.pf_pattern[3] : st_reg.pattern[3];

  dop_pulse_timer u_timer (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .t(bus_if.tmr)
  );

  dop_line4 u_line4 (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .l(bus_if.l4)
  );

  assign rdata_o = st_reg.rdata;
  assign lines_o = {bus_if.l4_level, st_reg.lines};

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_pattern_drive: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R01
    (wr_i && addr_i == dop_pkg::A_PATTERN && wdata_i <= dop_pkg::PATTERN_LIMIT
     && !st_reg.pf_active) |=> (st_reg.pattern == $past(wdata_i[3:0]))
     && (lines_o[2:0] == $past(wdata_i[2:0])))
    else $error("Base pattern not on lines");

  a_value_range: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R02
    (wr_i && addr_i == dop_pkg::A_PATTERN && wdata_i > dop_pkg::PATTERN_LIMIT)
    |=> (st_reg.pattern == $past(st_reg.pattern)) && st_reg.err)
    else $error("Out of range pattern accepted");

  a_clear_now: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R04
    (wr_i && addr_i == dop_pkg::A_CLEAR) |=> !st_reg.pf_active
    && (lines_o[2:0] == st_reg.pattern[2:0]) ##1 !bus_if.tmr_run)
    else $error("Clear did not restore base pattern");

  a_autoclr_off: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R05
    (st_reg.pf_active && !st_reg.auto_clr && !(wr_i && addr_i == dop_pkg::A_CLEAR))
    |=> st_reg.pf_active)
    else $error("Pass/fail ended without clear");

  a_autoclr_end: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R06
    (bus_if.tmr_done && st_reg.auto_clr && !(wr_i && addr_i == dop_pkg::A_PASSFAIL))
    |=> !st_reg.pf_active ##1 (lines_o[2:0] == st_reg.pattern[2:0] || st_reg.pf_active))
    else $error("Pass/fail not ended at timer expiry");

  a_read_ctrl: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R09
    (rd_i && addr_i == dop_pkg::A_CTRL) |=> (rdata_o[dop_pkg::C_AUTO] == st_reg.auto_clr)
    && (rdata_o[dop_pkg::C_MODE] == st_reg.l4_mode) && (rdata_o[dop_pkg::C_POL] == st_reg.l4_pol))
    else $error("Control readback wrong");

  a_text_bin: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R10
    (rd_i && addr_i == dop_pkg::A_TEXT && st_reg.fmt == dop_pkg::FMT_BIN)
    |=> (rdata_o[24] == $past(st_reg.pattern[3])) && (rdata_o[0] == $past(st_reg.pattern[0]))
    && (rdata_o[7:1] == dop_pkg::ASC_ZERO[7:1]))
    else $error("Binary text readback wrong");

  a_read_once: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R09
    !rd_i |=> (rdata_o == '0))
    else $error("Read data outside read slot");

  a_pf_show: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R06
    (wr_i && addr_i == dop_pkg::A_PASSFAIL && wdata_i <= dop_pkg::PATTERN_LIMIT)
    |=> st_reg.pf_active && (lines_o[2:0] == $past(wdata_i[2:0])))
    else $error("Pass/fail pattern not shown");

  a_timer_run: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R05
    (wr_i && addr_i == dop_pkg::A_PASSFAIL && wdata_i <= dop_pkg::PATTERN_LIMIT
     && st_reg.auto_clr && st_reg.delay != '0) |=> ##1 bus_if.tmr_run)
    else $error("Pulse timer not started");

  a_timer_idle: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R05
    (wr_i && addr_i == dop_pkg::A_PASSFAIL && wdata_i <= dop_pkg::PATTERN_LIMIT
     && !st_reg.auto_clr) |=> ##1 !bus_if.tmr_run)
    else $error("Pulse timer runs with auto-clear off");

  a_err_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R02
    (wr_i && addr_i == dop_pkg::A_STATUS && wdata_i[dop_pkg::S_ERR]) |=> !st_reg.err)
    else $error("Error flag not cleared");

  a_read_delay: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R09
    (rd_i && addr_i == dop_pkg::A_DELAY)
    |=> (rdata_o == dop_pkg::DATA_W'($past(st_reg.delay))))
    else $error("Delay readback wrong");

  a_read_pattern: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R09
    (rd_i && addr_i == dop_pkg::A_PATTERN)
    |=> (rdata_o == dop_pkg::DATA_W'($past(st_reg.pattern))))
    else $error("Pattern readback wrong");

  a_mode_select: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R07
    (wr_i && addr_i == dop_pkg::A_CTRL)
    |=> (bus_if.l4_mode == $past(wdata_i[dop_pkg::C_MODE]))
    && (bus_if.l4_pol == $past(wdata_i[dop_pkg::C_POL])))
    else $error("Line 4 mode not taken");

  a_text_dec: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R10
    (rd_i && addr_i == dop_pkg::A_TEXT && st_reg.fmt == dop_pkg::FMT_ASCII)
    |=> (rdata_o[7:4] == dop_pkg::ASC_ZERO[7:4]) && (rdata_o[31:16] == '0))
    else $error("Decimal text readback wrong");

  a_text_hex: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R10
    (rd_i && addr_i == dop_pkg::A_TEXT && st_reg.fmt == dop_pkg::FMT_HEX)
    |=> (rdata_o[31:8] == '0) && (rdata_o[7:4] != '0))
    else $error("Hex text readback wrong");

endmodule

// [tb/dop_handler_model.sv]
// Purpose: Test handler that takes the four port lines and watches line 4
// Assumes: Lines are sampled on the system clock
// Notes: Counts low strobes on line 4 and keeps the last strobe width
`timescale 1ns/1ps
module dop_handler_model (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [3:0] lines_i,
  output logic [15:0] strobe_cnt_o,
  output logic [15:0] strobe_len_o
);
  // ----------------------------------------
  // Line 4 strobe capture
  // ----------------------------------------
  logic [15:0] run_len;
  logic prev_l4;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strobe_cnt_o <= 16'h0000;
      strobe_len_o <= 16'h0000;
      run_len <= 16'h0000;
      prev_l4 <= 1'b1;
    end else begin
      prev_l4 <= lines_i[3];
      if (!lines_i[3]) begin
        run_len <= run_len + 16'h0001;
      end else if (!prev_l4) begin
        strobe_cnt_o <= strobe_cnt_o + 16'h0001;
        strobe_len_o <= run_len;
        run_len <= 16'h0000;
      end
    end
  end
endmodule

// [tb/digital_output_port_with_pulse_tb.sv]
// Purpose: Self-checking bench for the digital output port
// Assumes: 10 MHz clock, strobes driven right after the rising edge
// Notes: Reset defaults first, then table rows, timing, clear, line 4 and second reset cases
`timescale 1ns/1ps
module digital_output_port_with_pulse_tb;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  typedef struct {
    logic [7:0] wa;
    logic [31:0] wd;
    logic [7:0] ra;
    logic [31:0] exp;
  } dop_row_t;

  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h00000000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic meas_busy_i = 1'b0;
  logic test_done_i = 1'b0;
  logic [31:0] rdata_o;
  logic [3:0] lines_o;
  logic [15:0] strobe_cnt;
  logic [15:0] strobe_len;
  int err_count = 0;
  int checks = 0;
  logic [31:0] d;
  logic [15:0] c0;
  int n;
  dop_row_t rows [16];

  always #50 clk_sys_i = ~clk_sys_i;

  dop_port dut_u (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .meas_busy_i(meas_busy_i),
    .test_done_i(test_done_i), .lines_o(lines_o)
  );

  dop_handler_model handler_u (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .lines_i(lines_o),
    .strobe_cnt_o(strobe_cnt), .strobe_len_o(strobe_len)
  );

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic pulse_done();
    @(posedge clk_sys_i);
    test_done_i <= 1'b1;
    @(posedge clk_sys_i);
    test_done_i <= 1'b0;
  endtask

  // Cycles that the pass/fail value stays on the low lines
  task automatic pf_len(input logic [2:0] pf, output int cnt);
    bit ended;
    cnt = 0;
    ended = 1'b0;
    for (int i = 0; i < 1200 && !ended; i++) begin
      @(posedge clk_sys_i);
      #1;
      if (lines_o[2:0] === pf) begin
        cnt++;
      end else if (cnt > 0) begin
        ended = 1'b1;
      end
    end
    if (!ended) begin
      err_count++;
      report_and_stop();
    end
  endtask

  task automatic check_defaults();
    chk({28'h0000000, lines_o}, 32'h0000000f);
    rd(dop_pkg::A_PATTERN, d);
    chk(d, 32'h0000000f);
    rd(dop_pkg::A_CTRL, d);
    chk(d, 32'h00000000);
    rd(dop_pkg::A_DELAY, d);
    chk(d, 32'h00000001);
    rd(dop_pkg::A_TEXT, d);
    chk(d, 32'h00003135);
  endtask

  task automatic end_test(input string name);
    $display("test %s finished, mismatches so far %0d", name, err_count);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rows = '{
      '{dop_pkg::A_PATTERN, 32'h5, dop_pkg::A_PATTERN, 32'h5},
      '{dop_pkg::A_PATTERN, 32'h10, dop_pkg::A_PATTERN, 32'h5},
      '{dop_pkg::A_STATUS, 32'h0, dop_pkg::A_STATUS, 32'h45},
      '{dop_pkg::A_STATUS, 32'h40, dop_pkg::A_STATUS, 32'h5},
      '{dop_pkg::A_PATTERN, 32'hf, dop_pkg::A_TEXT, 32'h3135},
      '{dop_pkg::A_CTRL, 32'h10, dop_pkg::A_TEXT, 32'h46},
      '{dop_pkg::A_CTRL, 32'h20, dop_pkg::A_TEXT, 32'h3137},
      '{dop_pkg::A_PATTERN, 32'ha, dop_pkg::A_TEXT, 32'h3132},
      '{dop_pkg::A_CTRL, 32'h30, dop_pkg::A_TEXT, 32'h31303130},
      '{dop_pkg::A_CTRL, 32'h0, dop_pkg::A_TEXT, 32'h3130},
      '{dop_pkg::A_DELAY, 32'h927c0, dop_pkg::A_DELAY, 32'h927c0},
      '{dop_pkg::A_DELAY, 32'h927c1, dop_pkg::A_DELAY, 32'h927c0},
      '{8'h1c, 32'h5, 8'h1c, 32'h0},
      '{dop_pkg::A_CLEAR, 32'h0, dop_pkg::A_CLEAR, 32'h0},
      '{dop_pkg::A_CTRL, 32'h37, dop_pkg::A_CTRL, 32'h37},
      '{dop_pkg::A_CTRL, 32'h0, dop_pkg::A_CTRL, 32'h0}
    };
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    cyc(1);
    check_defaults();
    end_test("reset");
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd);
      cyc(1);
      rd(rows[i].ra, d);
      chk(d, rows[i].exp);
    end
    end_test("table");
    wr(dop_pkg::A_STATUS, 32'h40);
    wr(dop_pkg::A_CTRL, 32'h1);
    wr(dop_pkg::A_DELAY, 32'h1);
    wr(dop_pkg::A_PASSFAIL, 32'h6);
    pf_len(3'h6, n);
    chk(32'(n >= 1000 && n <= 1002), 32'h1);
    chk({29'h0, lines_o[2:0]}, 32'h2);
    wr(dop_pkg::A_DELAY, 32'h0);
    wr(dop_pkg::A_PASSFAIL, 32'h4);
    pf_len(3'h4, n);
    chk(32'(n >= 1 && n <= 3), 32'h1);
    end_test("auto clear");
    wr(dop_pkg::A_CTRL, 32'h0);
    wr(dop_pkg::A_PASSFAIL, 32'h5);
    cyc(50);
    chk({29'h0, lines_o[2:0]}, 32'h5);
    wr(dop_pkg::A_CLEAR, 32'h0);
    cyc(1);
    chk({29'h0, lines_o[2:0]}, 32'h2);
    wr(dop_pkg::A_CTRL, 32'h1);
    wr(dop_pkg::A_DELAY, 32'h5);
    wr(dop_pkg::A_PASSFAIL, 32'h5);
    cyc(10);
    rd(dop_pkg::A_STATUS, d);
    chk(d & 32'h90, 32'h90);
    wr(dop_pkg::A_CLEAR, 32'h0);
    cyc(1);
    chk({29'h0, lines_o[2:0]}, 32'h2);
    rd(dop_pkg::A_STATUS, d);
    chk(d & 32'h90, 32'h0);
    end_test("clear");
    wr(dop_pkg::A_CTRL, 32'h0);
    wr(dop_pkg::A_PATTERN, 32'hf);
    cyc(3);
    c0 = strobe_cnt;
    pulse_done();
    cyc(120);
    chk({16'h0, strobe_cnt}, {16'h0, c0 + 16'h1});
    chk({16'h0, strobe_len}, 32'd100);
    pulse_done();
    repeat (49) @(posedge clk_sys_i);
    pulse_done();
    cyc(170);
    chk({16'h0, strobe_cnt}, {16'h0, c0 + 16'h2});
    chk({16'h0, strobe_len}, 32'd151);
    end_test("end of test strobe");
    for (int p = 0; p < 2; p++) begin
      wr(dop_pkg::A_CTRL, p[0] ? 32'h6 : 32'h2);
      meas_busy_i <= 1'b1;
      cyc(3);
      chk({31'h0, lines_o[3]}, {31'h0, p[0]});
      rd(dop_pkg::A_STATUS, d);
      chk(d & 32'h20, 32'h20);
      @(posedge clk_sys_i);
      meas_busy_i <= 1'b0;
      cyc(3);
      chk({31'h0, lines_o[3]}, {31'h0, ~p[0]});
      pulse_done();
      cyc(2);
      chk({31'h0, lines_o[3]}, {31'h0, ~p[0]});
    end
    end_test("busy level");
    wr(dop_pkg::A_CTRL, 32'h35);
    wr(dop_pkg::A_PATTERN, 32'h3);
    @(posedge clk_sys_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    cyc(1);
    check_defaults();
    end_test("second reset");
    report_and_stop();
  end
endmodule
